/* out2_dac2_cfg.sv */
/*
  configuration register slice for output channel 2 and dac channel 2:
  output drive/level config, dac 2a volume and fine gain, dac 2b volume.
  assumes a simple synchronous control-port access (address, write strobe,
  write data, read data) decoded from the serial control port upstream.
*/
// Behaviour
// - driver field bits 7-6, reset line-out
// - level field bits 5-3, code 7 reserved
// - bit 2 selects bypass input impedance
// - bit 1 selects 2 or 4 Vrms fullscale
// - bit 0 selects coupling tolerance
// - 2A volume eight bits, zero mutes
// - volume 0.5 dB steps, 201 is unity
// - 2A volume at 0x6E, reset 0xC9
// - fine gain bits 7-4, code 8 unity
// - fine gain low nibble reads zero
// - fine gain at 0x6F, reset 0x80
// - output config at 0x6D, reset 0x20
// - 2B volume at 0x70, reset 0xC9
// - 2B volume uses same encoding
`timescale 1ns/1ps
`default_nettype none
`include "out2_dac2_regs.svh"

module out2_dac2_cfg
  import out2_dac2_pkg::*;
(
  // clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // control-port register access
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_hit,
  // output channel 2 configuration
  output driver_type_t           out_neg_driver_type,
  output logic [2:0]             out_neg_level_code,
  output logic                   out_level_reserved,
  output logic                   bypass_pos_input_impedance,
  output logic                   second_dac_fullscale_select,
  output logic                   second_dac_coupling_tolerance,
  // dac 2a volume and trim
  output logic [7:0]             second_dac_a_volume_code,
  output logic                   dac2a_mute,
  output logic signed [8:0]      dac2a_half_db,
  output logic [3:0]             second_dac_a_trim_gain,
  output logic signed [4:0]      dac2a_trim_tenth_db,
  // dac 2b volume
  output logic [7:0]             second_dac_b_volume_code,
  output logic                   dac2b_mute,
  output logic signed [8:0]      dac2b_half_db
);

  // decoding used by write and read paths alike
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // storage
  logic [7:0] out_cfg_reg;     // drive, level, impedance, fullscale, coupling
  logic [7:0] vol_a_reg;       // 2a volume code
  logic [3:0] trim_a_reg;      // 2a fine gain; reserved nibble not stored
  logic [7:0] vol_b_reg;       // 2b volume code
  wr_state_t  wr_state_reg;    // write sequencer
  wr_state_t  wr_state_next;
  logic [7:0] rdata_reg;       // registered read data

  // reset byte of the fine gain register; only its upper nibble is stored
  localparam logic [7:0] TRIM_RESET_BYTE = `DAC2A_TRIM_RESET;

  // address decode
  wire sel_cfg   = addr_is(reg_addr, `OUT2_CFG_ADDR);
  wire sel_vol_a = addr_is(reg_addr, `DAC2A_VOL_ADDR);
  wire sel_trim  = addr_is(reg_addr, `DAC2A_TRIM_ADDR);
  wire sel_vol_b = addr_is(reg_addr, `DAC2B_VOL_ADDR);
  wire sel_any   = sel_cfg | sel_vol_a | sel_trim | sel_vol_b;

  // write takes effect the same edge; the state only marks a write cycle
  wire wr_go = reg_wr & sel_any;

  // read mux: trim low nibble always zero, unmapped reads zero
  wire [7:0] trim_view = {trim_a_reg, 4'h0} & `TRIM_RSVD_MASK;
  wire [7:0] rd_mux    = sel_cfg   ? out_cfg_reg :
                         sel_vol_a ? vol_a_reg   :
                         sel_trim  ? trim_view   :
                         sel_vol_b ? vol_b_reg   : 8'h00;

  // write sequencer next state
  always_comb begin
    case (wr_state_reg)
      WR_IDLE:  wr_state_next = wr_go ? WR_APPLY : WR_IDLE;
      WR_APPLY: wr_state_next = wr_go ? WR_APPLY : WR_IDLE;
      default:  wr_state_next = WR_IDLE;
    endcase
  end

  // sequencer register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_state_reg <= WR_IDLE;
    end else if (clk_en) begin
      wr_state_reg <= wr_state_next;
    end
  end

  // output config register; all fields kept as written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_cfg_reg <= `OUT2_CFG_RESET;
    end else if (clk_en && reg_wr && sel_cfg) begin
      out_cfg_reg <= reg_wdata;
    end
  end

  // 2a volume register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_a_reg <= `DAC2A_VOL_RESET;
    end else if (clk_en && reg_wr && sel_vol_a) begin
      vol_a_reg <= reg_wdata;
    end
  end

  // 2a trim; reserved bits dropped so they can never read back nonzero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_a_reg <= TRIM_RESET_BYTE[`TRIM_MSB:`TRIM_LSB];
    end else if (clk_en && reg_wr && sel_trim) begin
      trim_a_reg <= reg_wdata[`TRIM_MSB:`TRIM_LSB];
    end
  end

  // 2b volume register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_b_reg <= `DAC2B_VOL_RESET;
    end else if (clk_en && reg_wr && sel_vol_b) begin
      vol_b_reg <= reg_wdata;
    end
  end

  // read data registered, held between reads
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (clk_en && reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // handshake: combinational hit flag for mapped addresses
  assign reg_hit   = sel_any & (reg_rd | reg_wr);
  assign reg_rdata = rdata_reg;

  // field outputs straight from the registers
  assign out_neg_driver_type           = driver_type_t'(out_cfg_reg[`DRIVER_MSB:`DRIVER_LSB]);
  assign out_neg_level_code            = out_cfg_reg[`LEVEL_MSB:`LEVEL_LSB];
  // reserved level code flagged; the analog side must not act on it
  assign out_level_reserved            = (out_neg_level_code == `LEVEL_RESERVED);
  assign bypass_pos_input_impedance    = out_cfg_reg[`BYP_IMP_BIT];
  // fullscale legality (2.75 V ref, audio band) is left to software
  assign second_dac_fullscale_select   = out_cfg_reg[`FULLSCALE_BIT];
  assign second_dac_coupling_tolerance = out_cfg_reg[`COUPLING_BIT];
  assign second_dac_a_volume_code      = vol_a_reg;
  assign second_dac_a_trim_gain        = trim_a_reg;
  assign second_dac_b_volume_code      = vol_b_reg;

  // 2a volume decode
  volume_decode u_vol_a (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .volume_code (vol_a_reg),
    .vol_mute    (dac2a_mute),
    .vol_half_db (dac2a_half_db)
  );

  // 2b volume decode, same encoding
  volume_decode u_vol_b (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .volume_code (vol_b_reg),
    .vol_mute    (dac2b_mute),
    .vol_half_db (dac2b_half_db)
  );

  // 2a fine gain decode
  trim_decode u_trim_a (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .trim_code     (trim_a_reg),
    .trim_tenth_db (dac2a_trim_tenth_db)
  );

endmodule
`default_nettype wire

/* out2_dac2_cfg_asserts.sv */
/*
  checker for out2_dac2_cfg: port-level timing of writes, reads and decodes.
  assumes it is bound to that module; one clock domain, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module out2_dac2_cfg_chk
  import out2_dac2_pkg::*;
(
  // clock and access
  input wire logic               sys_clk,
  input wire logic               rst_b,
  input wire logic               clk_en,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  // watched outputs
  input wire driver_type_t       out_neg_driver_type,
  input wire logic [2:0]         out_neg_level_code,
  input wire logic [7:0]         second_dac_a_volume_code,
  input wire logic               dac2a_mute,
  input wire logic signed [8:0]  dac2a_half_db,
  input wire logic [3:0]         second_dac_a_trim_gain,
  input wire logic signed [4:0]  dac2a_trim_tenth_db,
  input wire logic [7:0]         second_dac_b_volume_code,
  input wire logic               dac2b_mute
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // write data one edge back, so fields can be sliced from it
  logic [7:0] wd_reg;
  always_ff @(posedge sys_clk) begin
    wd_reg <= reg_wdata;
  end

  // taken writes per register
  wire w_cfg = clk_en && reg_wr && reg_addr == 8'h6D;
  wire w_va  = clk_en && reg_wr && reg_addr == 8'h6E;
  wire w_tr  = clk_en && reg_wr && reg_addr == 8'h6F;
  wire w_vb  = clk_en && reg_wr && reg_addr == 8'h70;

  property p_drv; w_cfg |=> out_neg_driver_type == driver_type_t'(wd_reg[7:6]); endproperty
  a_drv: assert property (p_drv) else $error("driver field not written");
  property p_lvl; w_cfg |=> out_neg_level_code == wd_reg[5:3]; endproperty
  a_lvl: assert property (p_lvl) else $error("level field not written");
  property p_va; w_va |=> second_dac_a_volume_code == wd_reg; endproperty
  a_va: assert property (p_va) else $error("volume a not written");
  property p_mta; clk_en |=> dac2a_mute == ($past(second_dac_a_volume_code) == 8'h00); endproperty
  a_mta: assert property (p_mta) else $error("mute a wrong");
  property p_hda;
    clk_en |=> dac2a_half_db == $signed({1'b0, $past(second_dac_a_volume_code)}) - 9'sd201;
  endproperty
  a_hda: assert property (p_hda) else $error("volume a decode wrong");
  property p_tr; w_tr |=> second_dac_a_trim_gain == wd_reg[7:4]; endproperty
  a_tr: assert property (p_tr) else $error("trim not written");
  property p_tdb;
    clk_en |=> dac2a_trim_tenth_db == $signed({1'b0, $past(second_dac_a_trim_gain)}) - 5'sd8;
  endproperty
  a_tdb: assert property (p_tdb) else $error("trim decode wrong");
  property p_rsv; clk_en && reg_rd && reg_addr == 8'h6F |=> reg_rdata[3:0] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved nibble not zero");
  property p_vb; w_vb |=> second_dac_b_volume_code == wd_reg; endproperty
  a_vb: assert property (p_vb) else $error("volume b not written");
  property p_mtb; clk_en |=> dac2b_mute == ($past(second_dac_b_volume_code) == 8'h00); endproperty
  a_mtb: assert property (p_mtb) else $error("mute b wrong");
endmodule

bind out2_dac2_cfg out2_dac2_cfg_chk chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .out_neg_driver_type(out_neg_driver_type),
  .out_neg_level_code(out_neg_level_code), .second_dac_a_volume_code(second_dac_a_volume_code),
  .dac2a_mute(dac2a_mute), .dac2a_half_db(dac2a_half_db),
  .second_dac_a_trim_gain(second_dac_a_trim_gain), .dac2a_trim_tenth_db(dac2a_trim_tenth_db),
  .second_dac_b_volume_code(second_dac_b_volume_code), .dac2b_mute(dac2b_mute));

`default_nettype wire

/* out2_dac2_pkg.sv */
/*
  types shared by the output-2 / dac-2 register slice.
  assumes the register header for widths and offsets.
*/
package out2_dac2_pkg;

  // output driver type codes
  typedef enum logic [1:0] {
    DRV_LINE_OUT  = 2'h0,
    DRV_HEADPHONE = 2'h1,
    DRV_FOUR_OHM  = 2'h2,
    DRV_RECV_DBG  = 2'h3
  } driver_type_t;

  // register write state: one-hot
  typedef enum logic [1:0] {
    WR_IDLE  = 2'b01,
    WR_APPLY = 2'b10
  } wr_state_t;

endpackage

/* out2_dac2_regs.svh */
/*
  register map of the output-2 / dac-2 configuration slice:
  offsets, reset values, field positions and decode constants.
  assumes nothing; definitions only.
*/
`ifndef OUT2_DAC2_REGS_SVH
`define OUT2_DAC2_REGS_SVH

// register offsets on the control port
`define OUT2_CFG_ADDR        8'h6D
`define DAC2A_VOL_ADDR       8'h6E
`define DAC2A_TRIM_ADDR      8'h6F
`define DAC2B_VOL_ADDR       8'h70

// reset values
`define OUT2_CFG_RESET       8'h20
`define DAC2A_VOL_RESET      8'hC9
`define DAC2A_TRIM_RESET     8'h80
`define DAC2B_VOL_RESET      8'hC9

// output config field positions
`define DRIVER_MSB           7
`define DRIVER_LSB           6
`define LEVEL_MSB            5
`define LEVEL_LSB            3
`define BYP_IMP_BIT          2
`define FULLSCALE_BIT        1
`define COUPLING_BIT         0

// fine gain field positions; low nibble reserved
`define TRIM_MSB             7
`define TRIM_LSB             4
`define TRIM_RSVD_MASK       8'hF0

// decode constants
`define LEVEL_RESERVED       3'h7
`define VOL_MUTE_CODE        8'h00
`define VOL_UNITY_CODE       8'hC9
`define TRIM_UNITY_CODE      4'h8

`endif

/* tb_top.sv */
/*
  tb_top: corner and random register traffic into out2_dac2_cfg, checked
  against a shadow copy. assumes the design files and the checker.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import out2_dac2_pkg::*;
;
  logic              sys_clk = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]        reg_addr = 0, reg_wdata = 0, reg_rdata, vol_a, vol_b, m [4];
  logic [2:0]        level;
  logic [3:0]        trim;
  logic signed [8:0] hdb_a, hdb_b;
  logic signed [4:0] tdb;
  logic              hit, lvl_rsv, byp, fsel, cpl, mute_a, mute_b;
  driver_type_t      drv;
  int                n_mismatch = 0, tests_run = 0;

  always #5 sys_clk = ~sys_clk;

  out2_dac2_cfg dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(hit),
    .out_neg_driver_type(drv), .out_neg_level_code(level), .out_level_reserved(lvl_rsv),
    .bypass_pos_input_impedance(byp), .second_dac_fullscale_select(fsel),
    .second_dac_coupling_tolerance(cpl), .second_dac_a_volume_code(vol_a),
    .dac2a_mute(mute_a), .dac2a_half_db(hdb_a), .second_dac_a_trim_gain(trim),
    .dac2a_trim_tenth_db(tdb), .second_dac_b_volume_code(vol_b), .dac2b_mute(mute_b),
    .dac2b_half_db(hdb_b));

  // counts every compare, reports a miss at once
  task automatic cmp(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  // volume code to half-dB steps, unity at 201
  function automatic logic signed [8:0] half_db(input logic [7:0] c);
    return $signed({1'b0, c}) - 9'sd201;
  endfunction

  // software duties kept by the stimulus: level 6 only with the 4.4 kohm
  // bypass setting, reserved fine-gain nibble written as zero; level 0 and
  // the fullscale conditions hang on parts outside this slice
  function automatic logic [7:0] legal_wd(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h6D && v[5:3] == 3'h6) v[2] = 1'b0;
    if (a == 8'h6F) v = v & 8'hF0;
    return v;
  endfunction

  // writes land only when mapped and enabled; trim low nibble never kept
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    #1;
    cmp(hit === (a >= 8'h6D && a <= 8'h70), "hit on write");
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a >= 8'h6D && a <= 8'h70 && clk_en) m[a - 8'h6D] = (a == 8'h6F) ? (d & 8'hF0) : d;
  endtask

  // unmapped reads must come back as zero
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    #1;
    cmp(hit === (a >= 8'h6D && a <= 8'h70), "hit on read");
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata === ((a >= 8'h6D && a <= 8'h70) ? m[a - 8'h6D] : 8'h00), "rdata");
  endtask

  // decoded outputs trail the registers, so wait two edges
  task automatic chk_all();
    repeat (2) @(posedge sys_clk);
    #1;
    cmp(drv === driver_type_t'(m[0][7:6]), "driver");
    cmp(level === m[0][5:3] && lvl_rsv === (m[0][5:3] == 3'h7), "level");
    cmp(byp === m[0][2], "bypass");
    cmp(fsel === m[0][1], "fullscale");
    cmp(cpl === m[0][0], "coupling");
    cmp(vol_a === m[1] && mute_a === (m[1] == 8'h00), "vol a");
    cmp(hdb_a === half_db(m[1]), "db a");
    cmp(trim === m[2][7:4] && tdb === $signed({1'b0, m[2][7:4]}) - 5'sd8, "trim");
    cmp(vol_b === m[3] && mute_b === (m[3] == 8'h00) && hdb_b === half_db(m[3]), "b");
  endtask

  initial begin
    logic [15:0] cn [12];
    logic [7:0]  a;
    // mute, bottom, unity, top, all drivers, reserved level, trim ends
    cn = '{16'h6E00, 16'h6E01, 16'h6EC9, 16'h6EFF, 16'h6D38, 16'h6D70, 16'h6DB3,
           16'h6DFF, 16'h6F00, 16'h6FF0, 16'h7000, 16'h70FF};
    void'($urandom(32'h0c4a_0813));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    m = '{8'h20, 8'hC9, 8'h80, 8'hC9};
    chk_all();
    for (int i = 0; i < 6; i++) rd(8'h6C + 8'(i));
    $display("test reset done");
    foreach (cn[i]) begin
      wr(cn[i][15:8], cn[i][7:0]);
      chk_all();
      rd(cn[i][15:8]);
    end
    $display("test corners done");
    // enable low: the write must be ignored
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h6E, 8'h55);
    chk_all();
    @(posedge sys_clk);
    clk_en <= 1'b1;
    $display("test enable done");
    repeat (60) begin
      a = 8'h6C + 8'($urandom_range(5));
      wr(a, legal_wd(a, 8'($urandom)));
      chk_all();
      rd(8'h6C + 8'($urandom_range(5)));
    end
    $display("test random done");
    // mid-run reset after non-reset contents: all back to reset values
    wr(8'h6E, 8'h00);
    wr(8'h6D, 8'hC7);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    m = '{8'h20, 8'hC9, 8'h80, 8'hC9};
    chk_all();
    rd(8'h6D);
    rd(8'h6F);
    $display("test mid reset done");
    give_verdict();
  end

  // hang guard, far beyond the roughly 480 cycles used
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule

`default_nettype wire

/* trim_decode.sv */
/*
  decodes the four-bit fine gain code into tenth-dB units
  (code 8 is 0 dB, step 0.1 dB, range -0.8 .. +0.7 dB).
  assumes a registered code at its input; output is registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "out2_dac2_regs.svh"

module trim_decode
  import out2_dac2_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // code in
  input  wire logic [3:0]        trim_code,
  // decoded out
  output logic signed [4:0]      trim_tenth_db
);

  // tenth-dB gain: code minus eight
  wire signed [4:0] tenth_w = $signed({1'b0, trim_code}) - $signed({1'b0, `TRIM_UNITY_CODE});

  // registered decoded gain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_tenth_db <= 5'sh00;
    end else if (clk_en) begin
      trim_tenth_db <= tenth_w;
    end
  end

endmodule
`default_nettype wire

/* volume_decode.sv */
/*
  decodes an eight-bit volume code into a mute flag and a signed
  gain in half-dB units (code 201 is 0, step 0.5 dB).
  assumes a registered code at its input; output is registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "out2_dac2_regs.svh"

module volume_decode
  import out2_dac2_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // code in
  input  wire logic [7:0]        volume_code,
  // decoded out
  output logic                   vol_mute,
  output logic signed [8:0]      vol_half_db
);

  // half-dB gain: code minus unity code, combinational
  wire signed [8:0] half_db_w = $signed({1'b0, volume_code}) - $signed({1'b0, `VOL_UNITY_CODE});
  wire              mute_w    = (volume_code == `VOL_MUTE_CODE);

  // registered decoded outputs; reset matches reset code 0xC9
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_mute    <= 1'b0;
      vol_half_db <= 9'sh000;
    end else if (clk_en) begin
      vol_mute    <= mute_w;
      vol_half_db <= half_db_w;
    end
  end

endmodule
`default_nettype wire
